// ==== rtl/fault_addr_capture.sv ====
/*
  fault address capture: memory and bus fault address registers,
  fault status, vector fetch flag, interrupt status and mask.
  assumes fault reports and register requests come from logic on i_clk.
*/
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
module fault_addr_capture (
  input  wire logic                          i_clk,     // processor clock, 40 MHz
  input  wire logic                          i_rst_n,   // async reset, active low
  input  wire logic                          i_ce,      // clock enable, freezes state
  input  wire fault_addr_pkg::reg_req_type   i_req,     // register port request
  output logic                        [31:0] o_rdata,   // read data, cycle after read
  output logic                               o_priv_err, // unprivileged access pulse
  input  wire fault_addr_pkg::fault_event_type i_fault, // fault report
  output logic                               o_mem_addr_valid, // memory address valid
  output logic                               o_bus_addr_valid, // bus address valid
  output logic                               o_vect_fault, // vector fetch fault flag
  output logic                               o_irq      // level interrupt
);

  logic [31:0]                    mem_addr;
  logic [31:0]                    bus_addr;
  logic                           mem_valid;
  logic                           bus_valid;
  logic                           mem_access;
  logic                           bus_precise;
  logic                           vect_flag;
  logic [fault_addr_pkg::IRQ_W-1:0] irq_status;
  logic [fault_addr_pkg::IRQ_W-1:0] irq_mask;

  // address decode
  wire sel_fault_status = i_req.addr == fault_addr_pkg::OFS_FAULT_STATUS;
  wire sel_hard_status  = i_req.addr == fault_addr_pkg::OFS_HARD_STATUS;
  wire sel_mem_addr     = i_req.addr == fault_addr_pkg::OFS_MEM_ADDR;
  wire sel_bus_addr     = i_req.addr == fault_addr_pkg::OFS_BUS_ADDR;
  wire sel_irq_status   = i_req.addr == fault_addr_pkg::OFS_IRQ_STATUS;
  wire sel_irq_mask     = i_req.addr == fault_addr_pkg::OFS_IRQ_MASK;

  // unprivileged strobes are dropped: writes ignored, reads give zero
  wire wr_ok    = i_req.wr & i_req.priv;
  wire rd_ok    = i_req.rd & i_req.priv;
  wire priv_bad = (i_req.wr | i_req.rd) & ~i_req.priv;

  // fault events by kind
  wire mem_ev  = i_fault.valid & (i_fault.kind == fault_addr_pkg::FAULT_MEM);
  wire bus_ev  = i_fault.valid & (i_fault.kind == fault_addr_pkg::FAULT_BUS);
  wire vect_ev = i_fault.valid & (i_fault.kind == fault_addr_pkg::FAULT_VECT);

  // write-one-to-clear strobes
  wire fs_wr     = wr_ok & sel_fault_status;
  wire mem_v_clr = fs_wr & i_req.wdata[fault_addr_pkg::MEM_VALID_BIT];
  wire mem_a_clr = fs_wr & i_req.wdata[fault_addr_pkg::MEM_ACCESS_BIT];
  wire bus_v_clr = fs_wr & i_req.wdata[fault_addr_pkg::BUS_VALID_BIT];
  wire bus_p_clr = fs_wr & i_req.wdata[fault_addr_pkg::BUS_PRECISE_BIT];
  wire vect_clr  = wr_ok & sel_hard_status & i_req.wdata[fault_addr_pkg::VECT_BIT];

  // first fault is kept until software releases the valid bit;
  // a fault in the clearing cycle is captured, not lost
  wire mem_load = mem_ev & (~mem_valid | mem_v_clr);
  wire bus_load = bus_ev & (~bus_valid | bus_v_clr);

  // memory fault keeps the sub-access that really faulted,
  // which the core guarantees lies inside the requested width
  wire [31:0] mem_load_addr = i_fault.act_addr;
  // bus fault keeps the address the instruction asked for
  wire [31:0] bus_load_addr = i_fault.req_addr;

  // sticky flags, set wins over clear
  wire next_mem_valid   = mem_ev | (mem_valid & ~mem_v_clr);
  wire next_mem_access  = mem_ev | (mem_access & ~mem_a_clr);
  wire next_bus_valid   = bus_ev | (bus_valid & ~bus_v_clr);
  wire next_bus_precise = bus_ev | (bus_precise & ~bus_p_clr);
  wire next_vect_flag   = vect_ev | (vect_flag & ~vect_clr);

  // interrupt status: events set, a privileged read clears
  wire [fault_addr_pkg::IRQ_W-1:0] irq_set = {priv_bad, vect_ev, bus_ev, mem_ev};
  wire irq_rd_clr = rd_ok & sel_irq_status;
  wire [fault_addr_pkg::IRQ_W-1:0] next_irq_status =
    irq_set | (irq_rd_clr ? {fault_addr_pkg::IRQ_W{1'b0}} : irq_status);
  wire [fault_addr_pkg::IRQ_W-1:0] next_irq_mask =
    (wr_ok & sel_irq_mask) ? i_req.wdata[fault_addr_pkg::IRQ_W-1:0] : irq_mask;

  // status word as software sees it; other bits read zero
  wire [31:0] fault_status_word =
    ({31'h0, mem_access} << fault_addr_pkg::MEM_ACCESS_BIT) |
    ({31'h0, mem_valid} << fault_addr_pkg::MEM_VALID_BIT) |
    ({31'h0, bus_precise} << fault_addr_pkg::BUS_PRECISE_BIT) |
    ({31'h0, bus_valid} << fault_addr_pkg::BUS_VALID_BIT);
  wire [31:0] hard_status_word = {31'h0, vect_flag} << fault_addr_pkg::VECT_BIT;

  // read mux; unmapped offsets read zero
  wire [31:0] rd_mux =
    sel_fault_status ? fault_status_word :
    sel_hard_status  ? hard_status_word :
    sel_mem_addr     ? mem_addr :
    sel_bus_addr     ? bus_addr :
    sel_irq_status   ? {28'h0, irq_status} :
    sel_irq_mask     ? {28'h0, irq_mask} : fault_addr_pkg::RDATA_ZERO;
  wire [31:0] next_rdata = rd_ok ? rd_mux : fault_addr_pkg::RDATA_ZERO;

  // address holding registers
  fault_addr_hold u_mem_hold (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_ce        (i_ce),
    .i_load      (mem_load),
    .i_load_addr (mem_load_addr),
    .i_wr        (wr_ok & sel_mem_addr),
    .i_wdata     (i_req.wdata),
    .o_addr      (mem_addr)
  );

  fault_addr_hold u_bus_hold (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_ce        (i_ce),
    .i_load      (bus_load),
    .i_load_addr (bus_load_addr),
    .i_wr        (wr_ok & sel_bus_addr),
    .i_wdata     (i_req.wdata),
    .o_addr      (bus_addr)
  );

  // status flags
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mem_valid   <= 1'b0;
      mem_access  <= 1'b0;
      bus_valid   <= 1'b0;
      bus_precise <= 1'b0;
      vect_flag   <= 1'b0;
    end else if (i_ce) begin
      mem_valid   <= next_mem_valid;
      mem_access  <= next_mem_access;
      bus_valid   <= next_bus_valid;
      bus_precise <= next_bus_precise;
      vect_flag   <= next_vect_flag;
    end
  end

  // interrupt status and mask
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_status <= {fault_addr_pkg::IRQ_W{1'b0}};
      irq_mask   <= fault_addr_pkg::MASK_RESET;
    end else if (i_ce) begin
      irq_status <= next_irq_status;
      irq_mask   <= next_irq_mask;
    end
  end

  // outputs straight from flops; irq lags status by one cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata          <= fault_addr_pkg::RDATA_ZERO;
      o_priv_err       <= 1'b0;
      o_mem_addr_valid <= 1'b0;
      o_bus_addr_valid <= 1'b0;
      o_vect_fault     <= 1'b0;
      o_irq            <= 1'b0;
    end else if (i_ce) begin
      o_rdata          <= next_rdata;
      o_priv_err       <= priv_bad;
      o_mem_addr_valid <= next_mem_valid;
      o_bus_addr_valid <= next_bus_valid;
      o_vect_fault     <= next_vect_flag;
      o_irq            <= |(irq_status & irq_mask);
    end
  end

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_mem_capture_exact: assert property (
    i_ce && mem_ev && !mem_valid |=> mem_valid && mem_addr == $past(i_fault.act_addr))
    else $error("memory fault address not captured exactly");

  a_mem_addr_width: assert property (
    i_ce && mem_ev && !mem_valid && i_fault.act_addr - i_fault.req_addr < (32'h1 << i_fault.size)
    |=> mem_addr - $past(i_fault.req_addr) < (32'h1 << $past(i_fault.size)))
    else $error("memory fault address outside access width");

  a_mem_hold_valid: assert property (
    i_ce && mem_valid && !mem_v_clr && !(wr_ok && sel_mem_addr) |=> $stable(mem_addr) && mem_valid)
    else $error("memory fault address changed while valid");

  a_bus_capture_req: assert property (
    i_ce && bus_ev && !bus_valid |=> bus_valid && bus_addr == $past(i_fault.req_addr))
    else $error("bus fault address is not the requested address");

  a_bus_hold_valid: assert property (
    i_ce && bus_valid && !bus_v_clr && !(wr_ok && sel_bus_addr) |=> $stable(bus_addr) && bus_valid)
    else $error("bus fault address changed while valid");

  a_unpriv_write_dropped: assert property (
    i_ce && i_req.wr && !i_req.priv && sel_irq_mask |=> $stable(irq_mask) && o_priv_err)
    else $error("unprivileged write took effect");

  a_unpriv_read_zero: assert property (
    i_ce && i_req.rd && !i_req.priv |=> o_rdata == 32'h0000_0000)
    else $error("unprivileged read returned data");

  a_status_reports_valid: assert property (
    i_ce && rd_ok && sel_fault_status |=>
    o_rdata[fault_addr_pkg::MEM_VALID_BIT] == $past(mem_valid) &&
    o_rdata[fault_addr_pkg::BUS_VALID_BIT] == $past(bus_valid))
    else $error("fault status does not report validity");

  a_vect_sticky_set: assert property (
    i_ce && vect_ev |=> vect_flag ##1 (vect_flag || $past(vect_clr)))
    else $error("vector fetch fault flag not set");

  a_vect_w1c: assert property (
    i_ce && vect_clr && !vect_ev |=> !vect_flag)
    else $error("vector fetch fault flag not cleared by one");

  a_irq_level: assert property (
    i_ce && |(irq_status & irq_mask) |=> o_irq)
    else $error("interrupt not raised for unmasked status");

  // sticky status flags: set by a fault, released by writing one
  a_mem_valid_set: assert property (
    i_ce && mem_ev |=> mem_valid && mem_access)
    else $error("memory fault status not set");

  a_bus_valid_set: assert property (
    i_ce && bus_ev |=> bus_valid && bus_precise)
    else $error("bus fault status not set");

  a_mem_valid_w1c: assert property (
    i_ce && mem_v_clr && !mem_ev |=> !mem_valid)
    else $error("memory address valid not cleared by one");

  a_bus_valid_w1c: assert property (
    i_ce && bus_v_clr && !bus_ev |=> !bus_valid)
    else $error("bus address valid not cleared by one");

  a_mem_access_w1c: assert property (
    i_ce && mem_a_clr && !mem_ev |=> !mem_access)
    else $error("memory access cause not cleared by one");

  a_bus_precise_w1c: assert property (
    i_ce && bus_p_clr && !bus_ev |=> !bus_precise)
    else $error("bus precise cause not cleared by one");

  a_vect_set_wins: assert property (
    i_ce && vect_ev && vect_clr |=> vect_flag)
    else $error("vector fetch fault lost against a clear");

  // capture while the valid bit is being released must not be lost
  a_mem_clear_capture: assert property (
    i_ce && mem_ev && mem_v_clr |=> mem_valid && mem_addr == $past(i_fault.act_addr))
    else $error("memory fault lost in the clearing cycle");

  a_bus_clear_capture: assert property (
    i_ce && bus_ev && bus_v_clr |=> bus_valid && bus_addr == $past(i_fault.req_addr))
    else $error("bus fault lost in the clearing cycle");

  a_load_beats_write: assert property (
    i_ce && mem_load && wr_ok && sel_mem_addr |=> mem_addr == $past(i_fault.act_addr))
    else $error("software write beat a memory fault capture");

  // software access to the address registers, privileged only
  a_mem_sw_write: assert property (
    i_ce && wr_ok && sel_mem_addr && !mem_load |=> mem_addr == $past(i_req.wdata))
    else $error("privileged write to memory fault address lost");

  a_bus_sw_write: assert property (
    i_ce && wr_ok && sel_bus_addr && !bus_load |=> bus_addr == $past(i_req.wdata))
    else $error("privileged write to bus fault address lost");

  a_unpriv_addr_kept: assert property (
    i_ce && priv_bad && !mem_load && !bus_load |=> $stable(mem_addr) && $stable(bus_addr))
    else $error("unprivileged access changed an address register");

  a_unpriv_flagged: assert property (
    i_ce && priv_bad |=> o_priv_err && irq_status[fault_addr_pkg::IRQ_PRIV])
    else $error("unprivileged access not flagged");

  a_priv_err_idle: assert property (
    i_ce && !priv_bad |=> !o_priv_err)
    else $error("privilege error without an unprivileged access");

  // read port: data only in the cycle after a privileged read
  a_rdata_idle_zero: assert property (
    i_ce && !rd_ok |=> o_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");

  a_unmapped_read_zero: assert property (
    i_ce && rd_ok && !(sel_fault_status || sel_hard_status || sel_mem_addr || sel_bus_addr ||
    sel_irq_status || sel_irq_mask) |=> o_rdata == 32'h0000_0000)
    else $error("unmapped offset read not zero");

  a_mem_addr_read: assert property (
    i_ce && rd_ok && sel_mem_addr |=> o_rdata == $past(mem_addr))
    else $error("memory fault address read wrong");

  a_bus_addr_read: assert property (
    i_ce && rd_ok && sel_bus_addr |=> o_rdata == $past(bus_addr))
    else $error("bus fault address read wrong");

  a_vect_status_read: assert property (
    i_ce && rd_ok && sel_hard_status |=>
    o_rdata[fault_addr_pkg::VECT_BIT] == $past(vect_flag) && o_rdata[31:2] == 30'h0 && !o_rdata[0])
    else $error("hard fault status read wrong");

  a_valid_outputs_track: assert property (
    o_mem_addr_valid == mem_valid && o_bus_addr_valid == bus_valid && o_vect_fault == vect_flag)
    else $error("valid outputs differ from status");

  // interrupt status, mask and level
  a_mask_write: assert property (
    i_ce && wr_ok && sel_irq_mask |=> irq_mask == $past(i_req.wdata[fault_addr_pkg::IRQ_W-1:0]))
    else $error("interrupt mask write lost");

  a_mask_read: assert property (
    i_ce && rd_ok && sel_irq_mask |=> o_rdata == {28'h0, $past(irq_mask)})
    else $error("interrupt mask read wrong");

  a_irq_read_clear: assert property (
    i_ce && irq_rd_clr |=> irq_status == $past(irq_set))
    else $error("interrupt status not cleared by read");

  a_irq_events_set: assert property (
    i_ce |=> (irq_status & $past(irq_set)) == $past(irq_set))
    else $error("interrupt event lost");

  a_irq_low: assert property (
    i_ce && !(|(irq_status & irq_mask)) |=> !o_irq)
    else $error("interrupt raised without unmasked status");

  // a low enable must freeze every register, outputs included
  a_ce_freeze: assert property (
    !i_ce |=> $stable(mem_addr) && $stable(bus_addr) && $stable(irq_status) && $stable(irq_mask) &&
    $stable(o_rdata) && $stable(o_irq) && $stable(vect_flag) && $stable(mem_valid) && $stable(bus_valid))
    else $error("state changed while clock enable low");

  c_mem_capture: cover property (i_ce && mem_load ##1 i_ce && rd_ok && sel_mem_addr);
  c_bus_capture: cover property (i_ce && bus_load ##1 i_ce && rd_ok && sel_bus_addr);
  c_vect_clear:  cover property (vect_flag ##1 i_ce && vect_clr);
  c_irq_raise:   cover property (!o_irq ##1 o_irq);
  c_unpriv_irq:  cover property (i_ce && priv_bad ##1 i_ce ##1 o_irq);

endmodule : fault_addr_capture

// ==== rtl/fault_addr_hold.sv ====
/*
  one fault address holding register.
  assumes load and write are qualified by the caller; load has priority.
*/
`timescale 1ns/10ps
module fault_addr_hold (
  input  wire logic        i_clk,   // processor clock
  input  wire logic        i_rst_n, // async reset, active low
  input  wire logic        i_ce,    // clock enable
  input  wire logic        i_load,  // capture a fault address
  input  wire logic [31:0] i_load_addr, // address to capture
  input  wire logic        i_wr,    // software write
  input  wire logic [31:0] i_wdata, // software write data
  output logic      [31:0] o_addr   // held address
);

  // hardware capture beats a software write in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_addr <= fault_addr_pkg::ADDR_RESET;
    end else if (i_ce && i_load) begin
      o_addr <= i_load_addr;
    end else if (i_ce && i_wr) begin
      o_addr <= i_wdata;
    end
  end

endmodule : fault_addr_hold

// ==== rtl/fault_addr_pkg.sv ====
/*
  constants, types and field layout for the fault address capture block.
  assumes a single processor clock and a plain word-wide register port.
*/
package fault_addr_pkg;

  // register byte offsets
  localparam logic [11:0] OFS_FAULT_STATUS = 12'hD28;
  localparam logic [11:0] OFS_HARD_STATUS  = 12'hD2C;
  localparam logic [11:0] OFS_MEM_ADDR     = 12'hD34;
  localparam logic [11:0] OFS_BUS_ADDR     = 12'hD38;
  localparam logic [11:0] OFS_IRQ_STATUS   = 12'hE00;
  localparam logic [11:0] OFS_IRQ_MASK     = 12'hE04;

  // fault status fields: memory byte low, bus byte above it
  localparam int MEM_ACCESS_BIT = 1;
  localparam int MEM_VALID_BIT  = 7;
  localparam int BUS_PRECISE_BIT = 9;
  localparam int BUS_VALID_BIT  = 15;
  // hard fault status field
  localparam int VECT_BIT       = 1;

  // interrupt status / mask layout
  localparam int IRQ_MEM  = 0;
  localparam int IRQ_BUS  = 1;
  localparam int IRQ_VECT = 2;
  localparam int IRQ_PRIV = 3;
  localparam int IRQ_W    = 4;

  // reset values
  localparam logic [31:0]       ADDR_RESET  = 32'h0000_0000;
  localparam logic [IRQ_W-1:0]  MASK_RESET  = 4'h0;
  localparam logic [31:0]       RDATA_ZERO  = 32'h0000_0000;

  typedef enum logic [1:0] {FAULT_MEM, FAULT_BUS, FAULT_VECT} fault_kind_type;

  // register port request, all fields valid in the strobe cycle
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic        priv;
  } reg_req_type;

  // fault report from the load/store and exception logic
  typedef struct packed {
    logic           valid;
    fault_kind_type kind;
    logic [31:0]    req_addr;
    logic [31:0]    act_addr;
    logic [1:0]     size;
  } fault_event_type;

endpackage : fault_addr_pkg

// ==== tb/fault_addr_capture_tb.sv ====
/*
  self-checking bench for the fault address capture block.
  assumes single clock, registered outputs and the register port of the package.
*/
`timescale 1ns/10ps
module fault_addr_capture_tb;
  logic                            i_clk, i_rst_n, i_ce, go, o_priv_err;
  logic                            o_mem_addr_valid, o_bus_addr_valid, o_vect_fault, o_irq;
  fault_addr_pkg::reg_req_type     i_req;
  fault_addr_pkg::fault_event_type i_fault;
  fault_addr_pkg::fault_kind_type  kind;
  logic [31:0]                     o_rdata, addr, seed;
  logic [1:0]                      size;
  logic [2:0]                      off;
  logic [11:0]                     ofs [6] = '{12'hD28, 12'hD2C, 12'hD34, 12'hD38, 12'hE04, 12'hFFC};
  int                              mismatches, check_count, m_mem, m_bus, m_fs, m_hs, m_irq, m_mask;

  fault_addr_capture u_fault_addr_capture (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_req(i_req),
    .o_rdata(o_rdata), .o_priv_err(o_priv_err), .i_fault(i_fault), .o_mem_addr_valid(o_mem_addr_valid),
    .o_bus_addr_valid(o_bus_addr_valid), .o_vect_fault(o_vect_fault), .o_irq(o_irq));
  fault_source u_fault_source (.i_clk(i_clk), .i_go(go), .i_kind(kind), .i_addr(addr), .i_size(size),
    .i_off(off), .o_fault(i_fault));

  // xorshift source, fixed start
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    if (mismatches == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  // one edge later: status levels and the interrupt level both settled
  task automatic settle();
    @(posedge i_clk);
    #1;
    check(o_mem_addr_valid, m_fs[7]);
    check(o_bus_addr_valid, m_fs[15]);
    check(o_vect_fault, m_hs[1]);
    check(o_irq, (m_irq & m_mask) != 0);
  endtask : settle

  task automatic wr(input logic [11:0] a, input int d, input logic p = 1'b1);
    @(posedge i_clk);
    i_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, priv: p};
    @(posedge i_clk);
    i_req.wr <= 1'b0;
    if (i_ce !== 1'b1) ;
    else if (!p) m_irq |= 8;
    else case (a)
      12'hD28: m_fs &= ~d;
      12'hD2C: m_hs &= ~d;
      12'hD34: m_mem = d;
      12'hD38: m_bus = d;
      12'hE04: m_mask = d & 15;
      default: ;
    endcase
    #1;
    check(o_priv_err, (!p && i_ce));
    settle();
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic p = 1'b1);
    int e;
    case (a)
      12'hD28: e = m_fs;
      12'hD2C: e = m_hs;
      12'hD34: e = m_mem;
      12'hD38: e = m_bus;
      12'hE00: e = m_irq;
      12'hE04: e = m_mask;
      default: e = 0;
    endcase
    @(posedge i_clk);
    i_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1, priv: p};
    @(posedge i_clk);
    i_req.rd <= 1'b0;
    if (!p) m_irq |= 8;
    else if (a == 12'hE00) m_irq = 0;
    #1;
    check(o_rdata, p ? e : 0);
    check(o_priv_err, !p);
    settle();
  endtask : rd

  task automatic flt(input fault_addr_pkg::fault_kind_type k, input logic [1:0] s);
    logic [31:0] act;
    @(posedge i_clk);
    go <= 1'b1;
    kind <= k;
    size <= s;
    addr <= rnd();
    off <= 3'(rnd());
    @(posedge i_clk);
    go <= 1'b0;
    act = addr + {29'h0, off & ~(3'h7 << s)};
    // first fault kept while its address is still valid
    case (k)
      fault_addr_pkg::FAULT_MEM: begin
        if (!m_fs[7]) m_mem = act;
        m_fs |= 32'h82;
        m_irq |= 1;
      end
      fault_addr_pkg::FAULT_BUS: begin
        if (!m_fs[15]) m_bus = addr;
        m_fs |= 32'h8200;
        m_irq |= 2;
      end
      default: begin
        m_hs |= 2;
        m_irq |= 4;
      end
    endcase
    @(posedge i_clk);
    settle();
  endtask : flt

  task automatic rdall();
    for (int i = 0; i < 6; i++) rd(ofs[i]);
  endtask : rdall

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge i_clk);
    mismatches++;
    conclude();
  end

  initial begin
    {seed, i_rst_n, i_ce, go, size, off, addr, i_req} = '0;
    seed = 32'h0000_0014;
    kind = fault_addr_pkg::FAULT_MEM;
    {mismatches, check_count, m_mem, m_bus, m_fs, m_hs, m_irq, m_mask} = '0;
    i_ce = 1'b1;
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rdall();
    wr(12'hE04, 1);
    flt(fault_addr_pkg::FAULT_BUS, 2);
    wr(12'hE04, 15);
    flt(fault_addr_pkg::FAULT_MEM, 2);
    flt(fault_addr_pkg::FAULT_MEM, 3);
    flt(fault_addr_pkg::FAULT_BUS, 1);
    flt(fault_addr_pkg::FAULT_VECT, 0);
    rdall();
    rd(12'hE00);
    rd(12'hD34, 1'b0);
    wr(12'hD38, rnd(), 1'b0);
    rd(12'hE00);
    wr(12'hD28, 32'h0000_0080);
    wr(12'hD2C, 0);
    wr(12'hD2C, 2);
    wr(12'hD38, rnd());
    rdall();
    flt(fault_addr_pkg::FAULT_MEM, 1);
    flt(fault_addr_pkg::FAULT_BUS, 3);
    // frozen clock enable drops the write
    @(posedge i_clk);
    i_ce <= 1'b0;
    wr(12'hE04, 0);
    @(posedge i_clk);
    i_ce <= 1'b1;
    rdall();
    conclude();
  end
endmodule : fault_addr_capture_tb

// ==== tb/fault_source.sv ====
/*
  fault report source standing in for the load/store and exception logic.
  assumes i_go is driven just after a rising edge and lasts one cycle.
*/
`timescale 1ns/10ps
module fault_source (
  input  wire logic                           i_clk,  // processor clock
  input  wire logic                           i_go,   // issue one report
  input  wire fault_addr_pkg::fault_kind_type i_kind, // fault kind
  input  wire logic [31:0]                    i_addr, // address the instruction asked for
  input  wire logic [1:0]                     i_size, // log2 of access bytes
  input  wire logic [2:0]                     i_off,  // byte of the aligned piece that faulted
  output fault_addr_pkg::fault_event_type     o_fault // report to the block
);
  // one-cycle report; idle address lines flip to their inverse every cycle, so stale values match only on every second idle cycle
  always_ff @(posedge i_clk) begin
    if (i_go) begin
      o_fault.valid    <= 1'b1;
      o_fault.kind     <= i_kind;
      o_fault.size     <= i_size;
      o_fault.req_addr <= i_addr;
      o_fault.act_addr <= i_addr + {29'h0, i_off & ~(3'h7 << i_size)};
    end else begin
      o_fault.valid    <= 1'b0;
      o_fault.req_addr <= ~o_fault.req_addr;
      o_fault.act_addr <= ~o_fault.act_addr;
    end
  end
endmodule : fault_source
